// ===== sim/ilrc_checker_test.sv
// self-checking testbench of the line resource checker
`timescale 1ns/1ns
`default_nettype none

module ilrc_checker_test;
   logic                   core_clk;        // 10 MHz core clock
   logic                   reset;           // sync reset
   logic                   send;            // request to the issue model
   ilrc_pkg::ilrc_line_t   send_line;       // line handed to the issue model
   logic                   line_valid;      // issue model to checker
   ilrc_pkg::ilrc_line_t   line_slots;      // issue model to checker
   logic                   result_valid;    // verdict pulse
   ilrc_pkg::ilrc_result_s result;          // verdict
   logic                   runtime_exc;     // alignment fault pulse
   int                     n_fail;          // mismatches
   int                     samples_checked; // comparisons

   ilrc_issue_model issue_u (.core_clk(core_clk), .reset(reset), .send(send),
      .send_line(send_line), .line_valid(line_valid), .line_slots(line_slots));
   ilrc_checker dut_u (.core_clk(core_clk), .reset(reset), .line_valid(line_valid),
      .line_slots(line_slots), .result_valid(result_valid), .result(result),
      .runtime_exc(runtime_exc));

   ////////////////////////////////////////////////////////////////////////////////
   // clock, time-zero values and watchdog
   always #50 core_clk = ~core_clk;
   initial begin
      core_clk  = 1'b0;
      reset     = 1'b1;
      send      = 1'b0;
      send_line = '0;
   end
   // the whole run is well under a hundred cycles
   initial begin
      #(3000 * 100);
      n_fail++;
      $display("FAIL at %0t: watchdog expired", $time);
      complete_run();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic ilrc_pkg::ilrc_slot_s mk(input ilrc_pkg::ilrc_itype_e it,
         input ilrc_pkg::ilrc_rclass_e s, input ilrc_pkg::ilrc_rclass_e d);
      ilrc_pkg::ilrc_slot_s r;
      r       = '0;
      r.valid = 1'b1;
      r.itype = it;
      r.src   = s;
      r.dst   = d;
      return r;
   endfunction
   task automatic chk_bit(input logic got, input logic exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL at %0t: %s got %b", $time, what, got);
      end
   endtask
   task automatic chk_vec(input logic [ilrc_pkg::NRES-1:0] got,
         input logic [ilrc_pkg::NRES-1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL at %0t: over got %h want %h", $time, got, exp);
      end
   endtask
   // the whole verdict in the cycle that result_valid stands
   task automatic chk_res(input logic el, input logic em,
         input logic [ilrc_pkg::NRES-1:0] eo, input logic ee);
      chk_bit(result_valid, 1'b1, "result_valid");
      chk_bit(result.legal, el, "legal");
      chk_bit(result.mod_err, em, "mod_err");
      chk_bit(runtime_exc, ee, "runtime_exc");
      chk_vec(result.over, eo);
   endtask
   // one line through the issue model, then wait for the verdict, bounded
   task automatic send_one(input ilrc_pkg::ilrc_line_t l);
      int k;
      @(posedge core_clk);
      send      <= 1'b1;
      send_line <= l;
      @(posedge core_clk);
      send <= 1'b0;
      for (k = 0; k < 4; k++) begin
         @(posedge core_clk);
         #1;
         if (result_valid === 1'b1) break;
      end
      if (k == 4) chk_bit(1'b0, 1'b1, "no verdict");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset;
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      #1;
      chk_bit(result_valid, 1'b0, "rv in reset");
      chk_bit(result.legal, 1'b0, "legal in reset");
      chk_vec(result.over, '0);
      $display("test reset done");
   endtask
   // four immediates: slots fit, address instructions and transfer path do not
   task automatic t_imm_budget;
      ilrc_pkg::ilrc_line_t l;
      logic [ilrc_pkg::NRES-1:0] e;
      for (int i = 0; i < 4; i++) l[i] = mk(ilrc_pkg::IT_IMM16, ilrc_pkg::RC_NONE,
         ilrc_pkg::RC_NONE);
      e = '0;
      e[ilrc_pkg::RES_INTEGER_ADDRESS_UNIT] = 1'b1;
      e[ilrc_pkg::RES_XFER] = 1'b1;
      send_one(l);
      chk_res(1'b0, 1'b0, e, 1'b0);
      $display("test imm budget done");
   endtask
   // conditional first, two long forms both want the second slot
   task automatic t_second_slot;
      ilrc_pkg::ilrc_line_t l;
      logic [ilrc_pkg::NRES-1:0] e;
      l    = '0;
      l[0] = mk(ilrc_pkg::IT_COND32, ilrc_pkg::RC_NONE, ilrc_pkg::RC_NONE);
      l[1] = mk(ilrc_pkg::IT_INTEGER_ADDRESS_UNIT_K32, ilrc_pkg::RC_NONE, ilrc_pkg::RC_NONE);
      e    = '0;
      e[ilrc_pkg::RES_SECOND] = 1'b1;
      send_one(l);
      chk_res(1'b0, 1'b0, e, 1'b0);
      $display("test second slot done");
   endtask
   // full legal mix, an over-budget slot marked invalid is ignored
   task automatic t_legal_mix;
      ilrc_pkg::ilrc_line_t l;
      l          = '0;
      l[0]       = mk(ilrc_pkg::IT_LD_J, ilrc_pkg::RC_NONE, ilrc_pkg::RC_XY);
      l[1]       = mk(ilrc_pkg::IT_ST_K, ilrc_pkg::RC_X, ilrc_pkg::RC_NONE);
      l[2]       = mk(ilrc_pkg::IT_OTHER, ilrc_pkg::RC_NONE, ilrc_pkg::RC_NONE);
      l[3]       = mk(ilrc_pkg::IT_IMM32, ilrc_pkg::RC_NONE, ilrc_pkg::RC_X);
      l[3].valid = 1'b0;
      send_one(l);
      chk_res(1'b1, 1'b0, '0, 1'b0);
      $display("test legal mix done");
   endtask
   // source only for transfer and store, destination only for written registers
   task automatic t_src_dst;
      ilrc_pkg::ilrc_line_t l;
      logic [ilrc_pkg::NRES-1:0] e;
      l    = '0;
      l[0] = mk(ilrc_pkg::IT_XFER, ilrc_pkg::RC_EXT, ilrc_pkg::RC_LINK);
      l[1] = mk(ilrc_pkg::IT_LD_J, ilrc_pkg::RC_EXT, ilrc_pkg::RC_LINK);
      l[2] = mk(ilrc_pkg::IT_ST_K, ilrc_pkg::RC_LINK, ilrc_pkg::RC_EXT);
      l[3] = mk(ilrc_pkg::IT_IMM16, ilrc_pkg::RC_NONE, ilrc_pkg::RC_LINK);
      e    = '0;
      e[ilrc_pkg::RES_INTEGER_ADDRESS_UNIT] = 1'b1;
      e[ilrc_pkg::RES_XFER] = 1'b1;
      e[ilrc_pkg::RES_LINK] = 1'b1;
      send_one(l);
      chk_res(1'b0, 1'b0, e, 1'b0);
      $display("test source dest done");
   endtask
   // post-modify doubles the j port; dma port holds exactly three
   task automatic t_postmod;
      ilrc_pkg::ilrc_line_t l;
      logic [ilrc_pkg::NRES-1:0] e;
      l             = '0;
      l[0]          = mk(ilrc_pkg::IT_LD_J, ilrc_pkg::RC_NONE, ilrc_pkg::RC_J);
      l[0].post_mod = 1'b1;
      l[1]          = mk(ilrc_pkg::IT_XFER, ilrc_pkg::RC_DMA, ilrc_pkg::RC_DMA);
      l[2]          = mk(ilrc_pkg::IT_LD_K, ilrc_pkg::RC_NONE, ilrc_pkg::RC_DMA);
      e             = '0;
      e[ilrc_pkg::RES_INTEGER_ADDRESS_UNIT]  = 1'b1;
      e[ilrc_pkg::RES_JPORT] = 1'b1;
      send_one(l);
      chk_res(1'b0, 1'b0, e, 1'b0);
      $display("test post modify done");
   endtask
   // misaligned pointer then bad modifier, back to back, verdict held after
   task automatic t_runtime;
      ilrc_pkg::ilrc_line_t a;
      ilrc_pkg::ilrc_line_t b;
      a             = '0;
      a[0]          = mk(ilrc_pkg::IT_LD_J, ilrc_pkg::RC_NONE, ilrc_pkg::RC_X);
      a[0].post_mod = 1'b1;
      a[0].quad     = 1'b1;
      a[0].ptr_lo   = 2'h2;
      b             = '0;
      b[0]          = mk(ilrc_pkg::IT_ST_K, ilrc_pkg::RC_X, ilrc_pkg::RC_NONE);
      b[0].post_mod = 1'b1;
      b[0].quad     = 1'b1;
      b[0].mod_lo   = 2'h1;
      @(posedge core_clk);
      send      <= 1'b1;
      send_line <= a;
      @(posedge core_clk);
      send_line <= b;
      @(posedge core_clk);
      send <= 1'b0;
      #1;
      chk_res(1'b1, 1'b0, '0, 1'b1);
      @(posedge core_clk);
      #1;
      chk_res(1'b0, 1'b1, '0, 1'b0);
      @(posedge core_clk);
      #1;
      chk_bit(result_valid, 1'b0, "rv after pulse");
      chk_bit(result.mod_err, 1'b1, "held verdict");
      $display("test runtime done");
   endtask
   // alignment buffers and sequencer port, then a five slot line
   task automatic t_dab_seq;
      ilrc_pkg::ilrc_line_t l;
      logic [ilrc_pkg::NRES-1:0] e;
      l    = '0;
      l[0] = mk(ilrc_pkg::IT_LD_J32, ilrc_pkg::RC_NONE, ilrc_pkg::RC_XYDAB);
      l[1] = mk(ilrc_pkg::IT_LD_K, ilrc_pkg::RC_NONE, ilrc_pkg::RC_XDAB);
      l[2] = mk(ilrc_pkg::IT_XFER, ilrc_pkg::RC_SEQ, ilrc_pkg::RC_Y);
      e    = '0;
      e[ilrc_pkg::RES_INTEGER_ADDRESS_UNIT] = 1'b1;
      e[ilrc_pkg::RES_XDAB] = 1'b1;
      send_one(l);
      chk_res(1'b0, 1'b0, e, 1'b0);
      l[0] = mk(ilrc_pkg::IT_COND, ilrc_pkg::RC_NONE, ilrc_pkg::RC_NONE);
      l[1] = mk(ilrc_pkg::IT_IMM32, ilrc_pkg::RC_NONE, ilrc_pkg::RC_K);
      l[2] = mk(ilrc_pkg::IT_ST_J, ilrc_pkg::RC_Y, ilrc_pkg::RC_NONE);
      l[3] = mk(ilrc_pkg::IT_INTEGER_ADDRESS_UNIT_J, ilrc_pkg::RC_NONE, ilrc_pkg::RC_NONE);
      e    = '0;
      e[ilrc_pkg::RES_SLOT] = 1'b1;
      e[ilrc_pkg::RES_INTEGER_ADDRESS_UNIT] = 1'b1;
      e[ilrc_pkg::RES_JU]   = 1'b1;
      send_one(l);
      chk_res(1'b0, 1'b0, e, 1'b0);
      $display("test buffers and slots done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      n_fail          = 0;
      samples_checked = 0;
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      t_imm_budget();
      t_second_slot();
      t_legal_mix();
      t_reset();
      t_src_dst();
      t_postmod();
      t_dab_seq();
      t_runtime();
      complete_run();
   end
endmodule // ilrc_checker_test

`default_nettype wire

// ===== sim/ilrc_issue_model.sv
// model of the fetch/issue stage that presents decoded lines to the checker
`timescale 1ns/1ns
`default_nettype none

module ilrc_issue_model (
   input  wire logic                 core_clk,   // core clock
   input  wire logic                 reset,      // sync reset, active high
   input  wire logic                 send,       // bench asks for one line
   input  wire ilrc_pkg::ilrc_line_t send_line,  // line to present
   output var  logic                 line_valid, // one-cycle line pulse
   output var  ilrc_pkg::ilrc_line_t line_slots  // decode fields
);
   ////////////////////////////////////////////////////////////////////////////////
   // one pulse per request, nothing while in reset
   always_ff @(posedge core_clk) begin
      if (reset) begin
         line_valid <= 1'b0;
      end else begin
         line_valid <= send;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // lines go out as composed; between lines the fields flip every cycle so a
   // checker that samples stale fields sees garbage rather than a kind repeat
   always_ff @(posedge core_clk) begin
      if (send && !reset) begin
         line_slots <= send_line;
      end else begin
         line_slots <= ~line_slots;
      end
   end
endmodule // ilrc_issue_model

`default_nettype wire

// ===== src/ilrc_checker.sv
// module: single-cycle resource checker for one decoded instruction line
`timescale 1ns/1ns
`default_nettype none

module ilrc_checker (
   input  wire logic                  core_clk,     // core clock, 10 MHz
   input  wire logic                  reset,        // sync reset, active high
   input  wire logic                  line_valid,   // pulse: a decoded line is present
   input  wire ilrc_pkg::ilrc_line_t  line_slots,   // decode fields of all four slots
   output var  logic                  result_valid, // pulse: verdict updated
   output var  ilrc_pkg::ilrc_result_s result,      // verdict, held until next line
   output var  logic                  runtime_exc   // pulse: runtime alignment fault
);

   ////////////////////////////////////////////////////////////////////////
   // decode helpers

   // memory load or store type
   function automatic logic is_mem(input ilrc_pkg::ilrc_itype_e t);
      is_mem = (t >= ilrc_pkg::IT_LD_J) && (t <= ilrc_pkg::IT_ST_K32);
   endfunction

   // add two usage vectors resource by resource
   function automatic ilrc_pkg::ilrc_use_t add_use(input ilrc_pkg::ilrc_use_t a,
                                                   input ilrc_pkg::ilrc_use_t b);
      ilrc_pkg::ilrc_use_t u;
      u = a;
      for (int r = 0; r < ilrc_pkg::NRES; r++) begin
         u[r] = a[r] + b[r];
      end
      add_use = u;
   endfunction

   // register port usage of one register class, as source or destination
   function automatic ilrc_pkg::ilrc_use_t port_use(input ilrc_pkg::ilrc_rclass_e rc,
                                                    input logic is_src);
      ilrc_pkg::ilrc_use_t u;
      logic xb;  // x block involved
      logic yb;  // y block involved
      logic dab; // goes through an alignment buffer
      u   = '0;
      xb  = 1'b0;
      yb  = 1'b0;
      dab = 1'b0;
      unique case (rc)
         ilrc_pkg::RC_NONE  : ;
         ilrc_pkg::RC_J     : u[ilrc_pkg::RES_JPORT] = 4'h1;
         ilrc_pkg::RC_K     : u[ilrc_pkg::RES_KPORT] = 4'h1;
         ilrc_pkg::RC_X     : xb = 1'b1;
         ilrc_pkg::RC_Y     : yb = 1'b1;
         ilrc_pkg::RC_XY    : begin                              // simd pair
            xb = 1'b1;
            yb = 1'b1;
         end
         ilrc_pkg::RC_XDAB  : begin
            xb  = 1'b1;
            dab = 1'b1;
         end
         ilrc_pkg::RC_YDAB  : begin
            yb  = 1'b1;
            dab = 1'b1;
         end
         ilrc_pkg::RC_XYDAB : begin
            xb  = 1'b1;
            yb  = 1'b1;
            dab = 1'b1;
         end
         ilrc_pkg::RC_SEQ   : u[ilrc_pkg::RES_SEQ]  = 4'h1;
         ilrc_pkg::RC_EXT   : u[ilrc_pkg::RES_EXT]  = 4'h1;
         ilrc_pkg::RC_DMA   : u[ilrc_pkg::RES_DMA]  = 4'h1;
         ilrc_pkg::RC_LINK  : u[ilrc_pkg::RES_LINK] = 4'h1;
         default            : ;                                  // unused code charges nothing
      endcase
      // sources leave by the output port, destinations enter by the input port
      u[ilrc_pkg::RES_XPORT] = u[ilrc_pkg::RES_XPORT] + 4'(xb);
      u[ilrc_pkg::RES_YPORT] = u[ilrc_pkg::RES_YPORT] + 4'(yb);
      if (is_src) begin
         u[ilrc_pkg::RES_XOUT] = 4'(xb);
         u[ilrc_pkg::RES_YOUT] = 4'(yb);
      end else begin
         u[ilrc_pkg::RES_XIN]  = 4'(xb);
         u[ilrc_pkg::RES_YIN]  = 4'(yb);
         u[ilrc_pkg::RES_XDAB] = 4'(xb & dab);
         u[ilrc_pkg::RES_YDAB] = 4'(yb & dab);
      end
      port_use = u;
   endfunction

   // full usage of one slot: base plus source plus destination
   function automatic ilrc_pkg::ilrc_use_t slot_use(input ilrc_pkg::ilrc_slot_s s);
      ilrc_pkg::ilrc_use_t u;
      logic none; // empty slot
      logic two;  // long form, takes the second slot too
      logic fst;  // needs the first slot
      logic integer_address_unit; // counts as integer-address instruction
      logic mv;   // uses the immediate-load / transfer path
      logic jx;   // uses the j side unit
      logic kx;   // uses the k side unit
      logic srr;  // source is a register
      logic dsr;  // destination is a register
      u    = '0;
      none = 1'b0;
      two  = 1'b0;
      fst  = 1'b0;
      integer_address_unit = 1'b0;
      mv   = 1'b0;
      jx   = 1'b0;
      kx   = 1'b0;
      srr  = 1'b0;
      dsr  = 1'b0;
      unique case (s.itype)
         ilrc_pkg::IT_NONE     : none = 1'b1;
         ilrc_pkg::IT_INTEGER_ADDRESS_UNIT_J   : {integer_address_unit, jx} = 2'h3;
         ilrc_pkg::IT_INTEGER_ADDRESS_UNIT_J32 : {two, integer_address_unit, jx} = 3'h7;
         ilrc_pkg::IT_INTEGER_ADDRESS_UNIT_K   : {integer_address_unit, kx} = 2'h3;
         ilrc_pkg::IT_INTEGER_ADDRESS_UNIT_K32 : {two, integer_address_unit, kx} = 3'h7;
         // a transfer never names a specific unit
         ilrc_pkg::IT_XFER     : {integer_address_unit, mv, srr, dsr} = 4'hF;
         ilrc_pkg::IT_IMM16    : {integer_address_unit, mv, dsr} = 3'h7;
         ilrc_pkg::IT_IMM32    : {two, integer_address_unit, mv, dsr} = 4'hF;
         ilrc_pkg::IT_LD_J     : {integer_address_unit, jx, dsr} = 3'h7;
         ilrc_pkg::IT_LD_J32   : {two, integer_address_unit, jx, dsr} = 4'hF;
         ilrc_pkg::IT_LD_K     : {integer_address_unit, kx, dsr} = 3'h7;
         ilrc_pkg::IT_LD_K32   : {two, integer_address_unit, kx, dsr} = 4'hF;
         ilrc_pkg::IT_ST_J     : {integer_address_unit, jx, srr} = 3'h7;
         ilrc_pkg::IT_ST_J32   : {two, integer_address_unit, jx, srr} = 4'hF;
         ilrc_pkg::IT_ST_K     : {integer_address_unit, kx, srr} = 3'h7;
         ilrc_pkg::IT_ST_K32   : {two, integer_address_unit, kx, srr} = 4'hF;
         ilrc_pkg::IT_COND     : fst = 1'b1;
         ilrc_pkg::IT_COND32   : {two, fst} = 2'h3;
         ilrc_pkg::IT_OTHER    : ;                                // slot only here
         default               : none = 1'b1;                     // illegal code charges nothing
      endcase
      // base usage, zero, one or two units of slots
      u[ilrc_pkg::RES_SLOT]   = none ? 4'h0 : (two ? 4'h2 : 4'h1);
      u[ilrc_pkg::RES_FIRST]  = 4'(fst);
      u[ilrc_pkg::RES_SECOND] = 4'(two);
      u[ilrc_pkg::RES_INTEGER_ADDRESS_UNIT]   = 4'(integer_address_unit);
      u[ilrc_pkg::RES_XFER]   = 4'(mv);
      u[ilrc_pkg::RES_JU]     = 4'(jx);
      u[ilrc_pkg::RES_KU]     = 4'(kx);
      // loads and immediates carry no source register
      if (srr) begin
         u = add_use(u, port_use(s.src, 1'b1));
      end
      if (dsr) begin
         u = add_use(u, port_use(s.dst, 1'b0));
      end
      // a post-modified pointer is written back through its unit port
      if (is_mem(s.itype) && s.post_mod) begin
         if (jx) begin
            u[ilrc_pkg::RES_JPORT] = u[ilrc_pkg::RES_JPORT] + 4'h1;
         end else begin
            u[ilrc_pkg::RES_KPORT] = u[ilrc_pkg::RES_KPORT] + 4'h1;
         end
      end
      slot_use = u;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // per-slot evaluation

   ilrc_pkg::ilrc_use_t        use_w [ilrc_pkg::NSLOT]; // usage of each slot
   logic [ilrc_pkg::NSLOT-1:0] mis_w;                   // runtime misaligned pointer
   logic [ilrc_pkg::NSLOT-1:0] moderr_w;                // static bad quad modifier

   // slot placement, circular indexing and destination clashes belong to the decoder;
   // only budgets and quad faults are judged here, so such lines still pass as legal
   for (genvar g = 0; g < ilrc_pkg::NSLOT; g++) begin : g_slot
      // empty slots add nothing
      assign use_w[g]    = line_slots[g].valid ? slot_use(line_slots[g]) : '0;
      // quad post-modify: pointer must be quad aligned at run time
      assign mis_w[g]    = line_slots[g].valid && is_mem(line_slots[g].itype) &&
                           line_slots[g].quad && line_slots[g].post_mod &&
                           (line_slots[g].ptr_lo != ilrc_pkg::ALIGN_OK);
      // quad post-modify: modifier must be a multiple of four
      assign moderr_w[g] = line_slots[g].valid && is_mem(line_slots[g].itype) &&
                           line_slots[g].quad && line_slots[g].post_mod &&
                           (line_slots[g].mod_lo != ilrc_pkg::ALIGN_OK);
   end

   ////////////////////////////////////////////////////////////////////////
   // line totals and verdict

   ilrc_pkg::ilrc_use_t         total_w; // summed usage of the line
   logic [ilrc_pkg::NRES-1:0]   over_w;  // total above budget
   ilrc_pkg::ilrc_result_s      res_d;   // next verdict

   // the whole line is summed in one cycle; counts cannot wrap, a slot adds at most two
   always_comb begin
      total_w = '0;
      for (int s = 0; s < ilrc_pkg::NSLOT; s++) begin
         total_w = add_use(total_w, use_w[s]);
      end
   end

   // compare every resource to its budget
   always_comb begin
      for (int r = 0; r < ilrc_pkg::NRES; r++) begin
         over_w[r] = total_w[r] > ilrc_pkg::BUDGET[r];
      end
   end

   // illegal when anything is over-subscribed or a static quad fault is seen
   always_comb begin
      res_d.over    = over_w;
      res_d.mod_err = |moderr_w;
      res_d.legal   = !(|over_w) && !(|moderr_w);
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs

   // verdict is held until the next line so issue logic may sample it late
   always_ff @(posedge core_clk) begin
      if (reset) begin
         result <= ilrc_pkg::RESULT_RST;
      end else if (line_valid) begin
         result <= res_d;
      end
   end

   // one pulse per line; the checker never stalls, so no line is ever held back
   always_ff @(posedge core_clk) begin
      if (reset) begin
         result_valid <= 1'b0;
      end else begin
         result_valid <= line_valid;
      end
   end

   // a runtime fault only raises a pulse; the line still completes
   // legal is left alone: a stray pointer is a run time fault, not a budget one
   always_ff @(posedge core_clk) begin
      if (reset) begin
         runtime_exc <= 1'b0;
      end else begin
         runtime_exc <= line_valid && (|mis_w);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   no_stall_a: assert property (line_valid |=> result_valid)
      else $error("line accepted without a verdict");

   idle_quiet_a: assert property (!line_valid |=> !result_valid && !runtime_exc &&
                                  $stable(result))
      else $error("outputs moved with no line");

   legal_tie_a: assert property (result_valid |-> result.legal ==
                                 (!(|result.over) && !result.mod_err))
      else $error("legal flag disagrees with faults");

   slot_budget_a: assert property (line_valid && total_w[ilrc_pkg::RES_SLOT] > 4'h4
                                   |=> result.over[ilrc_pkg::RES_SLOT] && !result.legal)
      else $error("more than four slots not flagged");

   dma_budget_a: assert property (line_valid && total_w[ilrc_pkg::RES_DMA] <= 4'h3
                                  |=> !result.over[ilrc_pkg::RES_DMA])
      else $error("three dma port units wrongly flagged");

   xfer_budget_a: assert property (line_valid && total_w[ilrc_pkg::RES_XFER] == 4'h2
                                   |=> result.over[ilrc_pkg::RES_XFER])
      else $error("second transfer path use not flagged");

   exc_raise_a: assert property (line_valid && (|mis_w) |=>
                                 runtime_exc && result_valid
                                 ##1 (!runtime_exc || $past(line_valid)))
      else $error("misaligned pointer raised no exception");

   exc_cause_a: assert property (runtime_exc |-> $past(line_valid) && $past(|mis_w))
      else $error("exception without a misaligned pointer");

   mod_err_a: assert property (line_valid && (|moderr_w) |=> result.mod_err &&
                               !result.legal)
      else $error("bad quad modifier not flagged");

   integer_address_unit_budget_a: assert property (line_valid && total_w[ilrc_pkg::RES_INTEGER_ADDRESS_UNIT] > 4'h2
                                   |=> result.over[ilrc_pkg::RES_INTEGER_ADDRESS_UNIT] && !result.legal)
      else $error("third address instruction not flagged");

   dab_budget_a: assert property (line_valid && total_w[ilrc_pkg::RES_XDAB] > 4'h1
                                  |=> result.over[ilrc_pkg::RES_XDAB])
      else $error("second x buffer load not flagged");

   unit_budget_a: assert property (line_valid && total_w[ilrc_pkg::RES_JU] > 4'h1
                                   |=> result.over[ilrc_pkg::RES_JU])
      else $error("second j unit user not flagged");

   // the fault pulse never comes alone: the line it belongs to is still answered
   exc_verdict_a: assert property (runtime_exc |-> result_valid)
      else $error("exception pulse without a verdict");

   legal_line_c: cover property (line_valid ##1 result_valid && result.legal);
   over_line_c:  cover property (line_valid ##1 result_valid && (|result.over));
   exc_line_c:   cover property (line_valid && (|mis_w) ##1 runtime_exc ##1 line_valid);
   full_line_c:  cover property (line_valid && total_w[ilrc_pkg::RES_SLOT] == 4'h4
                                 ##1 result.legal);
   dab_line_c:   cover property (line_valid && total_w[ilrc_pkg::RES_XDAB] == 4'h2);

endmodule // ilrc_checker

`default_nettype wire

// ===== src/ilrc_pkg.sv
// package: resource indices, budgets, decode codes and carriers of the line checker
package ilrc_pkg;

   localparam int NSLOT      = 4;  // slots in one line
   localparam int NRES       = 21; // tracked resources
   // resource indices
   localparam int RES_SLOT   = 0;  // instruction slots
   localparam int RES_FIRST  = 1;  // first slot
   localparam int RES_SECOND = 2;  // second slot
   localparam int RES_INTEGER_ADDRESS_UNIT   = 3;  // integer-address instructions
   localparam int RES_XFER   = 4;  // immediate-load / transfer path
   localparam int RES_JU     = 5;  // j_side_address_unit
   localparam int RES_KU     = 6;  // k_side_address_unit
   localparam int RES_JPORT  = 7;  // j unit register port
   localparam int RES_KPORT  = 8;  // k unit register port
   localparam int RES_XPORT  = 9;  // x block ports
   localparam int RES_XIN    = 10; // x block input ports
   localparam int RES_XOUT   = 11; // x block output port
   localparam int RES_XDAB   = 12; // x data_alignment_buffer
   localparam int RES_YPORT  = 13; // y block ports
   localparam int RES_YIN    = 14; // y block input ports
   localparam int RES_YOUT   = 15; // y block output port
   localparam int RES_YDAB   = 16; // y data_alignment_buffer
   localparam int RES_SEQ    = 17; // sequencer register port
   localparam int RES_EXT    = 18; // external port register port
   localparam int RES_DMA    = 19; // dma_register_port
   localparam int RES_LINK   = 20; // link register port

   typedef logic [NRES-1:0][3:0] ilrc_use_t; // usage count per resource

   // units available in one line, index 20 down to 0
   localparam ilrc_use_t BUDGET = {4'h3, 4'h3, 4'h1, 4'h1, 4'h1, 4'h1, 4'h2,
                                   4'h2, 4'h1, 4'h1, 4'h2, 4'h2, 4'h1, 4'h1,
                                   4'h1, 4'h1, 4'h1, 4'h2, 4'h1, 4'h1, 4'h4};
   localparam logic [1:0] ALIGN_OK = 2'h0; // quad aligned low address bits

   // instruction type codes from the decoder
   typedef enum logic [4:0] {
      IT_NONE     = 5'h00,
      IT_INTEGER_ADDRESS_UNIT_J   = 5'h01,
      IT_INTEGER_ADDRESS_UNIT_J32 = 5'h02,
      IT_INTEGER_ADDRESS_UNIT_K   = 5'h03,
      IT_INTEGER_ADDRESS_UNIT_K32 = 5'h04,
      IT_XFER     = 5'h05,
      IT_IMM16    = 5'h06,
      IT_IMM32    = 5'h07,
      IT_LD_J     = 5'h08,
      IT_LD_J32   = 5'h09,
      IT_LD_K     = 5'h0A,
      IT_LD_K32   = 5'h0B,
      IT_ST_J     = 5'h0C,
      IT_ST_J32   = 5'h0D,
      IT_ST_K     = 5'h0E,
      IT_ST_K32   = 5'h0F,
      IT_COND     = 5'h10,
      IT_COND32   = 5'h11,
      IT_OTHER    = 5'h12
   } ilrc_itype_e;

   // register class codes for source and destination
   typedef enum logic [3:0] {
      RC_NONE  = 4'h0,
      RC_J     = 4'h1,
      RC_K     = 4'h2,
      RC_X     = 4'h3,
      RC_Y     = 4'h4,
      RC_XY    = 4'h5,
      RC_XDAB  = 4'h6,
      RC_YDAB  = 4'h7,
      RC_XYDAB = 4'h8,
      RC_SEQ   = 4'h9,
      RC_EXT   = 4'hA,
      RC_DMA   = 4'hB,
      RC_LINK  = 4'hC
   } ilrc_rclass_e;

   typedef struct packed {
      logic         valid;    // slot holds an instruction
      ilrc_itype_e  itype;    // instruction type
      ilrc_rclass_e src;      // source register class
      ilrc_rclass_e dst;      // destination register class
      logic         post_mod; // address pointer post-modified
      logic         quad;     // quad-word access
      logic [1:0]   mod_lo;   // low bits of the modifier
      logic [1:0]   ptr_lo;   // low bits of the live pointer
   } ilrc_slot_s;

   typedef ilrc_slot_s [NSLOT-1:0] ilrc_line_t;

   typedef struct packed {
      logic            legal;   // line may issue
      logic            mod_err; // quad modifier not a multiple of four
      logic [NRES-1:0] over;    // resource over-subscribed
   } ilrc_result_s;

   localparam ilrc_result_s RESULT_RST = '0; // verdict after reset

endpackage
